// ===== pkg/ldp_defines.svh
// Purpose: named constants shared by both ends of the dimming link
// Assumes: included by bare name wherever a figure is needed
// Notes: widths of each macro match the signals that they meet
`ifndef LDP_DEFINES_SVH
`define LDP_DEFINES_SVH
// =====================================================================
// timing figures, in system clock cycles, and the frame length in bits
`define LDP_PWM_PERIOD 256
`define LDP_DC_UPDATE 1280
`define LDP_FRAME_BITS 32
`define LDP_CASCADE_HALF 4
`define LDP_CTRL_HALF 8
// =====================================================================
// duty codes and counter values
`define LDP_CODE_OFF 8'h00
`define LDP_CODE_TWO 8'h02
`define LDP_EFF_MIN 9'h002
`define LDP_EFF_OFF 9'h000
`define LDP_COUNT_FULL 6'h20
`define LDP_COUNT_ZERO 6'h00
// =====================================================================
// mode strap codes on the mode-select pin pair
`define LDP_STRAP_GND 2'h0
`define LDP_STRAP_OPEN 2'h1
`define LDP_STRAP_VCC 2'h2
`endif

// ===== pkg/ldp_pkg.sv
// Purpose: types for the led dimming pwm control link
// Assumes: nothing beyond the defines header
// Notes: all state codes are one-hot
package ldp_pkg;
  // =====================================================================
  // dimming mode, decoded from the strap
  typedef enum logic [2:0] {
    LDP_MODE_DIRECT = 3'h1,
    LDP_MODE_SERIAL = 3'h2,
    LDP_MODE_DC = 3'h4
  } ldp_mode_t;
  // =====================================================================
  // serializer states, one type for each end
  typedef enum logic [2:0] {
    LDP_TX_IDLE = 3'h1,
    LDP_TX_LOW = 3'h2,
    LDP_TX_HIGH = 3'h4
  } ldp_tx_t;
  typedef enum logic [3:0] {
    LDP_CT_IDLE = 4'h1,
    LDP_CT_LOW = 4'h2,
    LDP_CT_HIGH = 4'h4,
    LDP_CT_EOF = 4'h8
  } ldp_ctrl_t;
endpackage

// ===== pkg/ldp_link_if.sv
// Purpose: pin bundle between the dimming controller and the driver
// Assumes: both ends on the same system clock
// Notes: all pins are one-way, no enables needed
`timescale 1ns/1ps
`default_nettype none
interface ldp_link_if;
  logic [1:0] mode_strap; // board strap: 0 ground, 1 open, 2 logic supply
  logic group_a_dim_or_serial_data; // group a dim, or serial data
  logic group_b_dim_or_serial_clock; // group b dim, or bit clock
  logic group_c_dim_or_frame_end; // group c dim, or end-of-frame
  logic group_d_dim_input; // group d dim
  logic cascade_sync_out; // cascade data toward next unit
  logic cascade_serial_clock_out; // cascade clock toward next unit
  modport device (
    input mode_strap, group_a_dim_or_serial_data, group_b_dim_or_serial_clock,
    input group_c_dim_or_frame_end, group_d_dim_input,
    output cascade_sync_out, cascade_serial_clock_out
  );
  modport ctrl (
    output mode_strap, group_a_dim_or_serial_data, group_b_dim_or_serial_clock,
    output group_c_dim_or_frame_end, group_d_dim_input,
    input cascade_sync_out, cascade_serial_clock_out
  );
endinterface
`default_nettype wire

// ===== design/ldp_dimmer_device.sv
// How it works
// RL1 - ground strap picks direct, open picks serial
// RL2 - supply strap picks dc voltage mode
// RL3 - direct mode: group pins gate channels
// RL4 - serial bit taken on clock rising edge
// RL5 - 32 bits, then frame-end fall loads duties
// RL6 - bytes map to groups a, b, c, d
// RL7 - serial duty equals byte plus one over 256
// RL8 - codes one and two both give 2/256
// RL9 - zero is off, 0ffh is full on
// RL10 - pwm period is 256 system clocks
// RL11 - pick clock so one count lasts 8us
// RL12 - dc mode: each group code sets group
// RL13 - dc code follows linear voltage ramp
// RL14 - dc duties refresh every 1280 clocks
// RL15 - dc divisor stated 1280, equation 256
// RL16 - unpopulated channels disabled at rail ready
// RL17 - channel 0 always populated, five unused max
// RL18 - master forwards frames on sync and clock
// RL19 - slave acts as bit shift chain
// RL20 - dc master sends four codes serially
// RL21 - direct cascade shares pins, sync startup
// RL22 - msb first into 32-bit shift buffer
// RL23 - dc inputs arrive as 8-bit codes
//
// Purpose: driver-side dimming logic, six channels in four groups
// Assumes: strap, dim pins, rail ready and presence come from pins
// Notes: dc codes come from a converter on clk_in, so are not synchronised
`timescale 1ns/1ps
`default_nettype none
`include "ldp_defines.svh"
module ldp_dimmer_device
  import ldp_pkg::*;
#(
  parameter int DC_UPDATE = `LDP_DC_UPDATE, // dc refresh interval
  parameter int CASCADE_HALF = `LDP_CASCADE_HALF // half bit time of cascade clock
) (
  input wire logic clk_in,
  input wire logic reset_in,
  ldp_link_if.device link,
  input wire logic [7:0] dc_code_a_in,
  input wire logic [7:0] dc_code_b_in,
  input wire logic [7:0] dc_code_c_in,
  input wire logic [7:0] dc_code_d_in,
  input wire logic [5:0] channel_present_in,
  input wire logic rail_ready_in,
  input wire logic cascade_master_in,
  output logic [5:0] channel_pwm_out,
  output logic [5:0] channel_enabled_out
);
  // =====================================================================
  // pin synchronisers
  logic [1:0] strap_s1; // first stage, read only by strap_s2
  logic [1:0] strap_s2;
  logic [3:0] dim_s1; // first stage, read only by dim_s2
  logic [3:0] dim_s2;
  logic [3:0] dim_d; // previous dim_s2, for edge detection
  logic [1:0] rail_s; // rail ready chain
  logic rail_d;
  logic [5:0] present_s1; // first stage, read only by present_s2
  logic [5:0] present_s2;
  logic master_s1;
  logic master_s2;
  // every pin passes two flops before use
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strap_s1 <= `LDP_STRAP_GND;
      strap_s2 <= `LDP_STRAP_GND;
      dim_s1 <= 4'h0;
      dim_s2 <= 4'h0;
      dim_d <= 4'h0;
      rail_s <= 2'h0;
      rail_d <= 1'b0;
      present_s1 <= 6'h00;
      present_s2 <= 6'h00;
      master_s1 <= 1'b0;
      master_s2 <= 1'b0;
    end else begin
      strap_s1 <= link.mode_strap;
      strap_s2 <= strap_s1;
      dim_s1 <= {link.group_d_dim_input, link.group_c_dim_or_frame_end,
                 link.group_b_dim_or_serial_clock, link.group_a_dim_or_serial_data};
      dim_s2 <= dim_s1;
      dim_d <= dim_s2;
      rail_s <= {rail_s[0], rail_ready_in};
      rail_d <= rail_s[1];
      present_s1 <= channel_present_in;
      present_s2 <= present_s1;
      master_s1 <= cascade_master_in;
      master_s2 <= master_s1;
    end
  end
  // =====================================================================
  // mode decode
  ldp_mode_t mode;
  // strap is re-read every clock; a moving strap is a board fault
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode <= LDP_MODE_DIRECT;
    end else begin
      case (strap_s2)
        `LDP_STRAP_GND: mode <= LDP_MODE_DIRECT; // RL1
        `LDP_STRAP_OPEN: mode <= LDP_MODE_SERIAL; // RL1
        `LDP_STRAP_VCC: mode <= LDP_MODE_DC; // RL2
        default: mode <= LDP_MODE_DIRECT; // undefined strap falls back safe
      endcase
    end
  end
  logic bit_rise; // serial clock rising edge
  logic frame_fall; // end-of-frame falling edge
  assign bit_rise = dim_s2[1] & ~dim_d[1]; // RL4
  assign frame_fall = ~dim_s2[2] & dim_d[2]; // RL5
  // =====================================================================
  // serial receive
  logic [31:0] shift_buf; // frame being assembled
  logic [5:0] bit_count; // bits since last frame end, saturating
  logic [3:0][7:0] duty_code; // per group duty code, group a in [0]
  logic [10:0] update_count; // dc refresh timer
  logic dc_tick; // one-cycle dc update instant
  assign dc_tick = (update_count == 11'(DC_UPDATE - 1));
  // shift msb first; a frame with a bit count other than 32 is dropped
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shift_buf <= 32'h0000_0000;
      bit_count <= `LDP_COUNT_ZERO;
    end else if (mode != LDP_MODE_SERIAL) begin
      bit_count <= `LDP_COUNT_ZERO;
    end else if (frame_fall) begin
      bit_count <= `LDP_COUNT_ZERO; // RL5
    end else if (bit_rise) begin
      shift_buf <= {shift_buf[30:0], dim_s2[0]}; // RL22 RL19
      if (bit_count != `LDP_COUNT_FULL + 6'h01) begin
        bit_count <= bit_count + 6'h01;
      end
    end
  end
  // =====================================================================
  // duty registers
  // serial codes load on frame end, dc codes on each refresh tick
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      duty_code <= 32'h0000_0000;
    end else if (mode == LDP_MODE_SERIAL && frame_fall && bit_count == `LDP_COUNT_FULL) begin
      duty_code <= {shift_buf[7:0], shift_buf[15:8], shift_buf[23:16], shift_buf[31:24]}; // RL5 RL6
    end else if (mode == LDP_MODE_DC && dc_tick) begin
      duty_code <= {dc_code_d_in, dc_code_c_in, dc_code_b_in, dc_code_a_in}; // RL12 RL13 RL23
    end
  end
  // refresh timer free-runs so the update rate never drifts
  always_ff @(posedge clk_in) begin
    if (reset_in || dc_tick) begin
      update_count <= 11'h000;
    end else begin
      update_count <= update_count + 11'h001; // RL14 RL15
    end
  end
  // =====================================================================
  // pwm generation
  logic [7:0] pwm_count; // position in the 256-clock period
  logic [3:0] group_on; // compare result per group
  // wraps naturally at 256
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pwm_count <= 8'h00;
    end else begin
      pwm_count <= pwm_count + 8'h01; // RL10
    end
  end
  // code to on-count: zero stays off, one and two give two, else code+1
  function automatic logic [8:0] ldp_on_counts(input logic [7:0] code);
    logic [8:0] cnt;
    cnt = {1'b0, code} + 9'h001; // RL7
    if (code == `LDP_CODE_OFF) begin
      cnt = `LDP_EFF_OFF; // RL9
    end else if (code <= `LDP_CODE_TWO) begin
      cnt = `LDP_EFF_MIN; // RL8
    end
    return cnt;
  endfunction
  for (genvar g = 0; g < 4; g++) begin : g_group
    // 0ffh gives 256 on-counts, so the compare is always true
    assign group_on[g] = ({1'b0, pwm_count} < ldp_on_counts(duty_code[g])); // RL9
  end
  // =====================================================================
  // channel enable test
  logic tested; // the presence test runs once per reset
  // presence is caught on the rising rail ready, held until restart
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tested <= 1'b0;
      channel_enabled_out <= 6'h00;
    end else if (!tested && rail_s[1] && !rail_d) begin
      tested <= 1'b1;
      channel_enabled_out <= present_s2; // RL16
    end
  end
  // channel to group: 0,1 a; 2,3 b; 4 c; 5 d
  for (genvar c = 0; c < 6; c++) begin : g_chan
    localparam int GRP = (c < 4) ? (c / 2) : (c - 2);
    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        channel_pwm_out[c] <= 1'b0;
      end else if (mode == LDP_MODE_DIRECT) begin
        channel_pwm_out[c] <= dim_s2[GRP] & channel_enabled_out[c]; // RL3
      end else begin
        channel_pwm_out[c] <= group_on[GRP] & channel_enabled_out[c]; // RL12 RL16
      end
    end
  end
  // =====================================================================
  // cascade output
  ldp_tx_t tx_state; // dc master serializer
  logic [31:0] tx_buf; // codes awaiting transmission
  logic [5:0] tx_bits; // bits still to send
  logic [3:0] tx_timer; // half bit timer
  logic hold_high; // serial forward clock pulse active
  // serial: forward the bit that falls out of the buffer with a pulse;
  // dc master: serialise codes; direct master: sync shows startup finished
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_state <= LDP_TX_IDLE;
      tx_buf <= 32'h0000_0000;
      tx_bits <= `LDP_COUNT_ZERO;
      tx_timer <= 4'h0;
      hold_high <= 1'b0;
      link.cascade_sync_out <= 1'b0;
      link.cascade_serial_clock_out <= 1'b0;
    end else if (mode == LDP_MODE_SERIAL) begin
      tx_state <= LDP_TX_IDLE;
      if (bit_rise) begin
        link.cascade_sync_out <= shift_buf[31]; // RL18 RL19
        tx_timer <= 4'h0;
        hold_high <= 1'b1;
        link.cascade_serial_clock_out <= 1'b0;
      end else if (hold_high) begin
        // data settles a half bit before the forwarded clock rises
        tx_timer <= tx_timer + 4'h1;
        if (tx_timer == 4'(CASCADE_HALF - 1)) begin
          link.cascade_serial_clock_out <= 1'b1;
        end else if (tx_timer == 4'(2 * CASCADE_HALF - 1)) begin
          link.cascade_serial_clock_out <= 1'b0;
          hold_high <= 1'b0;
        end
      end
    end else if (mode == LDP_MODE_DC && master_s2) begin
      case (tx_state)
        LDP_TX_IDLE: begin
          link.cascade_serial_clock_out <= 1'b0;
          if (dc_tick) begin
            tx_buf <= {dc_code_a_in, dc_code_b_in, dc_code_c_in, dc_code_d_in}; // RL20
            tx_bits <= `LDP_COUNT_FULL;
            tx_timer <= 4'h0;
            tx_state <= LDP_TX_LOW;
          end
        end
        LDP_TX_LOW: begin
          link.cascade_sync_out <= tx_buf[31]; // RL20 RL22
          tx_timer <= tx_timer + 4'h1;
          if (tx_timer == 4'(CASCADE_HALF - 1)) begin
            tx_timer <= 4'h0;
            link.cascade_serial_clock_out <= 1'b1;
            tx_state <= LDP_TX_HIGH;
          end
        end
        LDP_TX_HIGH: begin
          tx_timer <= tx_timer + 4'h1;
          if (tx_timer == 4'(CASCADE_HALF - 1)) begin
            tx_timer <= 4'h0;
            link.cascade_serial_clock_out <= 1'b0;
            tx_buf <= {tx_buf[30:0], 1'b0};
            tx_bits <= tx_bits - 6'h01;
            tx_state <= (tx_bits == 6'h01) ? LDP_TX_IDLE : LDP_TX_LOW;
          end
        end
        default: tx_state <= LDP_TX_IDLE;
      endcase
    end else begin
      tx_state <= LDP_TX_IDLE;
      hold_high <= 1'b0;
      link.cascade_serial_clock_out <= 1'b0;
      link.cascade_sync_out <= tested & master_s2; // RL21
    end
  end
endmodule // ldp_dimmer_device
`default_nettype wire

// ===== design/ldp_dimmer_ctrl.sv
// Purpose: external dimming controller end of the link
// Assumes: frames handed over on clk_in with valid/ready
// Notes: bit time is two CTRL_HALF periods; slow it for real boards
`timescale 1ns/1ps
`default_nettype none
`include "ldp_defines.svh"
module ldp_dimmer_ctrl
  import ldp_pkg::*;
#(
  parameter int CTRL_HALF = `LDP_CTRL_HALF // half bit time in clocks
) (
  input wire logic clk_in,
  input wire logic reset_in,
  ldp_link_if.ctrl link,
  input wire logic [1:0] mode_strap_in,
  input wire logic [3:0] direct_dim_in,
  input wire logic [31:0] frame_in,
  input wire logic frame_valid_in,
  output logic frame_ready_out,
  output logic frame_done_out
);
  // =====================================================================
  // frame serializer
  ldp_ctrl_t state; // current step of the frame
  logic [31:0] buffer; // frame, first byte in the top bits
  logic [5:0] bits_left; // bits still to clock out
  logic [4:0] timer; // half bit timer
  logic serial_mode;
  assign serial_mode = (mode_strap_in == `LDP_STRAP_OPEN); // RL1
  // strap is a board level, passed straight to the pin
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      link.mode_strap <= `LDP_STRAP_GND;
    end else begin
      link.mode_strap <= mode_strap_in; // RL1 RL2
    end
  end
  // frame end is held high while bits move, its fall marks the load
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= LDP_CT_IDLE;
      buffer <= 32'h0000_0000;
      bits_left <= `LDP_COUNT_ZERO;
      timer <= 5'h00;
      frame_ready_out <= 1'b0;
      frame_done_out <= 1'b0;
      link.group_a_dim_or_serial_data <= 1'b0;
      link.group_b_dim_or_serial_clock <= 1'b0;
      link.group_c_dim_or_frame_end <= 1'b0;
      link.group_d_dim_input <= 1'b0;
    end else if (!serial_mode) begin
      // direct and dc modes: pins follow the user levels, one flop late
      state <= LDP_CT_IDLE;
      frame_ready_out <= 1'b0;
      frame_done_out <= 1'b0;
      {link.group_d_dim_input, link.group_c_dim_or_frame_end,
       link.group_b_dim_or_serial_clock, link.group_a_dim_or_serial_data} <= direct_dim_in; // RL21
    end else begin
      frame_done_out <= 1'b0;
      link.group_d_dim_input <= 1'b0; // unused pin held low in serial mode
      case (state)
        LDP_CT_IDLE: begin
          link.group_b_dim_or_serial_clock <= 1'b0;
          link.group_c_dim_or_frame_end <= 1'b0;
          frame_ready_out <= 1'b1;
          if (frame_valid_in && frame_ready_out) begin
            frame_ready_out <= 1'b0;
            buffer <= frame_in;
            bits_left <= `LDP_COUNT_FULL; // RL5
            timer <= 5'h00;
            link.group_c_dim_or_frame_end <= 1'b1;
            state <= LDP_CT_LOW;
          end
        end
        LDP_CT_LOW: begin
          link.group_a_dim_or_serial_data <= buffer[31]; // RL22
          timer <= timer + 5'h01;
          if (timer == 5'(CTRL_HALF - 1)) begin
            timer <= 5'h00;
            link.group_b_dim_or_serial_clock <= 1'b1; // RL4
            state <= LDP_CT_HIGH;
          end
        end
        LDP_CT_HIGH: begin
          timer <= timer + 5'h01;
          if (timer == 5'(CTRL_HALF - 1)) begin
            timer <= 5'h00;
            link.group_b_dim_or_serial_clock <= 1'b0;
            buffer <= {buffer[30:0], 1'b0};
            bits_left <= bits_left - 6'h01;
            state <= (bits_left == 6'h01) ? LDP_CT_EOF : LDP_CT_LOW;
          end
        end
        LDP_CT_EOF: begin
          timer <= timer + 5'h01;
          if (timer == 5'(CTRL_HALF - 1)) begin
            timer <= 5'h00;
            link.group_c_dim_or_frame_end <= 1'b0; // RL5
            frame_done_out <= 1'b1;
            state <= LDP_CT_IDLE;
          end
        end
        default: state <= LDP_CT_IDLE;
      endcase
    end
  end
endmodule // ldp_dimmer_ctrl
`default_nettype wire

// ===== tb/ldp_link_monitor.sv
// Purpose: wire-level checks on the serial dimming link
// Assumes: one clock; interface signals fed in as plain inputs
// Notes: level lengths use counters, not long repeats
`timescale 1ns/1ps
`default_nettype none
module ldp_link_monitor #(
  parameter int CTRL_HALF = 4,
  parameter int CASCADE_HALF = 2
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] mode_strap,
  input wire logic group_a_dim_or_serial_data,
  input wire logic group_b_dim_or_serial_clock,
  input wire logic group_c_dim_or_frame_end,
  input wire logic cascade_sync_out,
  input wire logic cascade_serial_clock_out
);
  // =====================================================================
  // helper counters
  int hi_cnt; // cycles the bit clock has been high
  int lo_cnt; // cycles the bit clock has been low
  int c_hi_cnt; // cycles the cascade clock has been high
  int rise_cnt; // bit clock rises inside the current frame
  wire sclk = group_b_dim_or_serial_clock;
  wire cclk = cascade_serial_clock_out;
  wire serial = (mode_strap == 2'h1);
  // level counters clear on the opposite level
  always_ff @(posedge clk_in) begin
    hi_cnt <= (reset_in || !sclk) ? 0 : hi_cnt + 1;
    lo_cnt <= (reset_in || sclk) ? 0 : lo_cnt + 1;
    c_hi_cnt <= (reset_in || !cclk) ? 0 : c_hi_cnt + 1;
  end
  // frame bit count, cleared outside a frame so a short frame shows up
  always_ff @(posedge clk_in) begin
    if (reset_in || !group_c_dim_or_frame_end) begin
      rise_cnt <= 0;
    end else if ($rose(sclk)) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  // =====================================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_SCLK_HIGH: assert property (serial && $fell(sclk) |-> hi_cnt == CTRL_HALF)
    else $error("bit clock high time wrong");
  AST_SCLK_LOW: assert property (serial && $rose(sclk) && rise_cnt != 0 |-> lo_cnt == CTRL_HALF)
    else $error("bit clock low time wrong");
  AST_DATA_HOLD: assert property (serial && sclk && $past(sclk) |-> $stable(group_a_dim_or_serial_data))
    else $error("data moved while bit clock high");
  AST_RISE_IN_FRAME: assert property (serial && $rose(sclk) |-> group_c_dim_or_frame_end)
    else $error("bit clock outside frame");
  AST_EOF_COUNT: assert property (serial && $fell(group_c_dim_or_frame_end) |-> rise_cnt == 32 && !sclk)
    else $error("frame end after wrong bit count");
  AST_CASC_HIGH: assert property ($fell(cclk) |-> c_hi_cnt == CASCADE_HALF)
    else $error("cascade clock high time wrong");
  AST_CASC_HOLD: assert property (cclk && $past(cclk) |-> $stable(cascade_sync_out))
    else $error("sync moved while cascade clock high");
  AST_DIRECT_QUIET: assert property (mode_strap == 2'h0 |-> !cclk)
    else $error("cascade clock runs in direct mode");
  // main scenarios reached
  cover property (serial && $fell(group_c_dim_or_frame_end));
  cover property (serial && $rose(cclk));
  cover property (mode_strap == 2'h2 && $rose(cclk));
endmodule // ldp_link_monitor
`default_nettype wire

// ===== tb/test_led_dimming_pwm_control.sv
// Purpose: self-checking bench for both ends of the dimming link
// Assumes: shortened half-bit and dc update counts
// Notes: a second device on a bench-driven link takes the bad frames
`timescale 1ns/1ps
`default_nettype none
module test_led_dimming_pwm_control;
  // =====================================================================
  // stimulus and observation
  localparam int CH = 4; // controller half bit
  localparam int CA = 2; // cascade half bit
  localparam int DU = 160; // dc refresh, longer than one cascade send
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] mode_strap_in = 2'h0;
  logic [3:0] direct_dim_in = 4'h0;
  logic [31:0] frame_in = 32'h0000_0000;
  logic frame_valid_in = 1'b0;
  logic frame_ready_out, frame_done_out;
  logic [31:0] dc_codes = 32'h0000_0000;
  logic [5:0] presence = 6'h37; // channel 3 unpopulated
  logic rail_ready = 1'b0;
  logic master = 1'b1;
  logic [5:0] pwm, en, pwm2, en2;
  logic [31:0] sbits, cbits; // bits as a far unit would take them
  int scnt = 0;
  int ccnt = 0;
  int on [6];
  int on2;
  int failures = 0;
  int tests_run = 0;
  ldp_link_if link ();
  ldp_link_if bad_link ();
  ldp_dimmer_ctrl #(.CTRL_HALF(CH)) u_ldp_dimmer_ctrl (.clk_in(clk_in), .reset_in(reset_in), .link(link),
    .mode_strap_in(mode_strap_in), .direct_dim_in(direct_dim_in), .frame_in(frame_in),
    .frame_valid_in(frame_valid_in), .frame_ready_out(frame_ready_out), .frame_done_out(frame_done_out));
  ldp_dimmer_device #(.DC_UPDATE(DU), .CASCADE_HALF(CA)) u_ldp_dimmer_device (.clk_in(clk_in),
    .reset_in(reset_in), .link(link), .dc_code_a_in(dc_codes[31:24]), .dc_code_b_in(dc_codes[23:16]),
    .dc_code_c_in(dc_codes[15:8]), .dc_code_d_in(dc_codes[7:0]), .channel_present_in(presence),
    .rail_ready_in(rail_ready), .cascade_master_in(master), .channel_pwm_out(pwm), .channel_enabled_out(en));
  ldp_dimmer_device #(.DC_UPDATE(DU), .CASCADE_HALF(CA)) u_ldp_dimmer_device_bad (.clk_in(clk_in),
    .reset_in(reset_in), .link(bad_link), .dc_code_a_in(dc_codes[31:24]), .dc_code_b_in(dc_codes[23:16]),
    .dc_code_c_in(dc_codes[15:8]), .dc_code_d_in(dc_codes[7:0]), .channel_present_in(presence),
    .rail_ready_in(rail_ready), .cascade_master_in(master), .channel_pwm_out(pwm2), .channel_enabled_out(en2));
  ldp_link_monitor #(.CTRL_HALF(CH), .CASCADE_HALF(CA)) u_ldp_link_monitor (.clk_in(clk_in),
    .reset_in(reset_in), .mode_strap(link.mode_strap), .group_a_dim_or_serial_data(link.group_a_dim_or_serial_data),
    .group_b_dim_or_serial_clock(link.group_b_dim_or_serial_clock),
    .group_c_dim_or_frame_end(link.group_c_dim_or_frame_end), .cascade_sync_out(link.cascade_sync_out),
    .cascade_serial_clock_out(link.cascade_serial_clock_out));
  always #2.5 clk_in = ~clk_in;
  // capture on rising clocks, the way a receiving unit would
  always @(posedge clk_in) begin
    if (link.mode_strap == 2'h1 && $rose(link.group_b_dim_or_serial_clock)) begin
      sbits <= {sbits[30:0], link.group_a_dim_or_serial_data};
      scnt <= scnt + 1;
    end
    if ($rose(link.cascade_serial_clock_out)) begin
      cbits <= {cbits[30:0], link.cascade_sync_out};
      ccnt <= ccnt + 1;
    end
  end
  // =====================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic give_up();
    failures++;
    summarize();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // on-count per period for a duty code
  function automatic int exp_on(input logic [7:0] c);
    if (c == 8'h00) return 0;
    if (c <= 8'h02) return 2;
    return c + 1;
  endfunction
  // count high cycles over one full pwm period
  task automatic measure();
    on = '{default: 0};
    on2 = 0;
    repeat (256) begin
      @(negedge clk_in);
      for (int i = 0; i < 6; i++) on[i] += pwm[i];
      on2 += pwm2[0];
    end
  endtask
  // channels 0,1 group a; 2,3 group b; 4 c; 5 d
  task automatic check_groups(input logic [31:0] codes);
    int g;
    for (int i = 0; i < 6; i++) begin
      g = (i < 2) ? 0 : (i < 4) ? 1 : i - 2;
      check(on[i], presence[i] ? exp_on(codes[31 - 8 * g -: 8]) : 0);
    end
  endtask
  // hand a frame to the controller and watch it cross the wire
  task automatic send_frame(input logic [31:0] v);
    int n, s0;
    for (n = 0; frame_ready_out !== 1'b1; n++) begin
      if (n == 3000) give_up();
      @(negedge clk_in);
    end
    frame_in = v;
    frame_valid_in = 1'b1;
    s0 = scnt;
    @(posedge clk_in);
    @(negedge clk_in);
    frame_valid_in = 1'b0;
    for (n = 0; frame_done_out !== 1'b1; n++) begin
      if (n == 3000) give_up();
      @(negedge clk_in);
    end
    check(scnt - s0, 32);
    check(sbits, v);
    cycles(10);
  endtask
  // bench plays a controller that may miscount bits
  task automatic raw_frame(input logic [31:0] v, input int n);
    bad_link.group_c_dim_or_frame_end = 1'b1;
    for (int i = 0; i < n; i++) begin
      bad_link.group_a_dim_or_serial_data = v[(31 - i) & 31];
      cycles(4);
      bad_link.group_b_dim_or_serial_clock = 1'b1;
      cycles(4);
      bad_link.group_b_dim_or_serial_clock = 1'b0;
    end
    cycles(4);
    bad_link.group_c_dim_or_frame_end = 1'b0;
    cycles(10);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_enable();
    direct_dim_in = 4'hF;
    cycles(10);
    check(en, 6'h00);
    check(pwm, 6'h00);
    rail_ready = 1'b1;
    cycles(10);
    check(en, presence);
    check(en2, presence);
  endtask
  task automatic t_direct();
    logic [3:0] pat [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
    for (int k = 0; k < 4; k++) begin
      direct_dim_in = pat[k];
      cycles(8);
      check(pwm, {pat[k][3], pat[k][2], {2{pat[k][1]}}, {2{pat[k][0]}}} & presence);
    end
    check(link.cascade_sync_out, 1'b1);
  endtask
  task automatic t_serial();
    int c0;
    mode_strap_in = 2'h1;
    send_frame(32'h0001_02FF);
    measure();
    check_groups(32'h0001_02FF);
    c0 = ccnt;
    send_frame(32'h80FE_7F03);
    check(ccnt - c0, 32);
    check(cbits, 32'h0001_02FF);
    measure();
    check_groups(32'h80FE_7F03);
  endtask
  task automatic t_refuse();
    raw_frame(32'hFF00_0000, 32);
    measure();
    check(on2, 256);
    raw_frame(32'h0000_0000, 31);
    measure();
    check(on2, 256);
    raw_frame(32'h0000_0000, 33);
    measure();
    check(on2, 256);
  endtask
  task automatic t_dc();
    int n, c0;
    dc_codes = 32'h1001_FE00;
    mode_strap_in = 2'h2;
    c0 = ccnt;
    for (n = 0; ccnt - c0 < 32; n++) begin
      if (n == 1000) give_up();
      @(negedge clk_in);
    end
    check(cbits, 32'h1001_FE00);
    cycles(DU + 10);
    measure();
    check_groups(32'h1001_FE00);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    bad_link.mode_strap = 2'h1;
    bad_link.group_a_dim_or_serial_data = 1'b0;
    bad_link.group_b_dim_or_serial_clock = 1'b0;
    bad_link.group_c_dim_or_frame_end = 1'b0;
    bad_link.group_d_dim_input = 1'b0;
    cycles(3);
    reset_in = 1'b0;
    t_enable();
    t_direct();
    t_serial();
    t_refuse();
    t_dc();
    summarize();
  end
endmodule // test_led_dimming_pwm_control
`default_nettype wire
